/* File: design/atx_pkg.sv */
// constants, register map and types for the transmit encoder
package atx_pkg;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam int ADDR_W = 12;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_OUT  = 12'h004;
	localparam logic [11:0] REG_CU   = 12'h008;
	localparam logic [11:0] REG_STAT = 12'h00c;
	localparam logic [11:0] UA_BASE  = 12'h100;
	localparam logic [11:0] UA_LAST  = 12'h15c;
	// control register fields
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_DIV_LSB = 2;
	localparam int CTRL_MSRC    = 4;
	localparam int CTRL_VALID   = 5;
	localparam int CTRL_BSDIR   = 6;
	// output register fields
	localparam int OUT_LD_OFF   = 0;
	localparam int OUT_CB_OFF   = 1;
	localparam int OUT_MUTE     = 2;
	localparam int OUT_LD_BYP   = 3;
	localparam int OUT_CB_BYP   = 4;
	localparam int OUT_BYP_LSB  = 5;
	// channel-status/user source register fields
	localparam int CU_SRC_LSB   = 0;
	localparam int CU_VSEL      = 2;
	// status register fields
	localparam int STAT_SYNC    = 8;
	// reset values and bus response codes
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] OUT_RST  = 8'h00;
	localparam logic [7:0] CU_RST   = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ************************************************************
	// frame layout
	// ************************************************************
	localparam int BLK_BITS = 192;
	localparam logic [7:0] FRAME_LAST = 8'hbf;
	localparam logic [6:0] HC_LAST    = 7'h7f;
	localparam logic [5:0] SF_LAST    = 6'h3f;
	localparam logic [4:0] PRE_SLOTS  = 5'h04;
	localparam int AUD_LSB = 4;
	localparam int AUD_MSB = 27;
	localparam int SF_V = 28;
	localparam int SF_U = 29;
	localparam int SF_C = 30;
	localparam int SF_P = 31;
	// preamble half-cell patterns, first half-cell in the msb, after a low level
	localparam logic [7:0] PRE_X = 8'he2;
	localparam logic [7:0] PRE_Y = 8'he4;
	localparam logic [7:0] PRE_Z = 8'he8;
	// ************************************************************
	// enumerations
	// ************************************************************
	typedef enum logic [1:0] {
		ATX_SRC_PORT_A = 2'b00,
		ATX_SRC_PORT_B = 2'b01,
		ATX_SRC_RX     = 2'b10
	} atx_src_t;
	typedef enum logic [1:0] {
		ATX_CU_USER = 2'b00,
		ATX_CU_RX   = 2'b01
	} atx_cu_t;
endpackage

/* File: design/atx_tx_encoder_unit.sv */
// aes3 transmit encoder with axi4-lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// - each frame: channel 1 subframe first, then channel 2 subframe
// - subframe: 4 preamble slots, 24 data bits, then V, U, C, P
// - X starts channel 1, Y channel 2, Z replaces X every 192nd frame
// - block of 192 frames; 24 status and 24 user bytes per channel
// - audio in bits 4..27, lsb at bit 4; 20-bit audio leaves 4..7 auxiliary
// - validity 0 means sample usable, 1 means unusable
// - parity bit makes bits 4..31 carry even number of ones
// - data bits biphase mark coded; preambles violate the coding
// - audio from port A, port B or receiver; port A after reset
// - frame rate from selected master clock divided by 128/256/384/512
// - status/user bits via tx access buffers, filled from user or rx buffers
// - receiver-sourced status/user data lags its audio by one block
// - validity from host bit (default) or receiver bit per frame
// - each output selects encoder or one of four bypassed line inputs
// - disable bits force line driver or cmos buffer output low
// - mute zeroes audio and aux bits, keeps V U C, recomputes parity
// - direction bit sets block-start pin input (reset) or output
// - block-start input forces Z preamble on the next frame
// - frame-sync clock rises at the start of every encoded frame
// - as output, block start is generated from internal frame sync
module atx_tx_encoder_unit (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [23:0] port_a_left,
	input  wire logic [23:0] port_a_right,
	input  wire logic [23:0] port_b_left,
	input  wire logic [23:0] port_b_right,
	input  wire logic [23:0] rx_left,
	input  wire logic [23:0] rx_right,
	input  wire logic        rx_validity,
	input  wire logic        rx_cu_strobe,
	input  wire logic        rx_block_start,
	input  wire logic [3:0]  rx_cu_bits,
	input  wire logic        ext_mclk,
	input  wire logic        recovered_clock_out,
	input  wire logic [3:0]  line_rx_in,
	output logic             line_out,
	output logic             cmos_out,
	output logic             sync_out,
	input  wire logic        block_start_pin_i,
	output logic             block_start_pin_o,
	output logic             block_start_pin_oe
);
	// ************************************************************
	// register bus slave
	// ************************************************************
	logic [7:0]   ctrl_reg;
	logic [7:0]   out_reg;
	logic [7:0]   cu_reg;
	logic         aw_full_reg;
	logic [11:0]  aw_addr_reg;
	logic         w_full_reg;
	logic [31:0]  w_data_reg;
	logic [3:0]   w_strb_reg;
	logic         bvalid_reg;
	logic [1:0]   bresp_reg;
	logic         rvalid_reg;
	logic [31:0]  rdata_reg;
	logic [1:0]   rresp_reg;
	logic [3:0][191:0] ua_reg;
	logic [3:0][191:0] ta_reg;
	logic [3:0][191:0] ra_cap_reg;
	logic [3:0][191:0] ra_done_reg;
	logic [7:0]   ra_idx_reg;
	logic [6:0]   hc_reg;
	logic [7:0]   frame_reg;

	// write decode
	wire        do_write = aw_full_reg & w_full_reg & ~bvalid_reg;
	wire        wr_lo    = do_write & w_strb_reg[0];
	wire        ua_wr_hit = (aw_addr_reg >= atx_pkg::UA_BASE) &
	                        (aw_addr_reg <= atx_pkg::UA_LAST) & (aw_addr_reg[1:0] == 2'h0);
	wire [11:0] ua_wofs  = aw_addr_reg - atx_pkg::UA_BASE;
	wire [4:0]  ua_widx  = ua_wofs[6:2];
	wire        wr_known = (aw_addr_reg == atx_pkg::REG_CTRL) |
	                       (aw_addr_reg == atx_pkg::REG_OUT) |
	                       (aw_addr_reg == atx_pkg::REG_CU) |
	                       (aw_addr_reg == atx_pkg::REG_STAT) | ua_wr_hit;
	wire        ar_take  = s_axi_arvalid & ~rvalid_reg;
	wire        ua_rd_hit = (s_axi_araddr >= atx_pkg::UA_BASE) &
	                        (s_axi_araddr <= atx_pkg::UA_LAST) & (s_axi_araddr[1:0] == 2'h0);
	wire [11:0] ua_rofs  = s_axi_araddr - atx_pkg::UA_BASE;
	wire [4:0]  ua_ridx  = ua_rofs[6:2];
	wire [31:0] ua_rword = {ua_reg[3][{ua_ridx, 3'h0} +: 8], ua_reg[2][{ua_ridx, 3'h0} +: 8],
	                        ua_reg[1][{ua_ridx, 3'h0} +: 8], ua_reg[0][{ua_ridx, 3'h0} +: 8]};
	wire [31:0] stat_word = {23'h0, ~hc_reg[6], frame_reg};
	wire        rd_known = (s_axi_araddr == atx_pkg::REG_CTRL) |
	                       (s_axi_araddr == atx_pkg::REG_OUT) |
	                       (s_axi_araddr == atx_pkg::REG_CU) |
	                       (s_axi_araddr == atx_pkg::REG_STAT) | ua_rd_hit;
	wire [31:0] rd_mux   = (s_axi_araddr == atx_pkg::REG_CTRL) ? {24'h0, ctrl_reg} :
	                       (s_axi_araddr == atx_pkg::REG_OUT)  ? {24'h0, out_reg} :
	                       (s_axi_araddr == atx_pkg::REG_CU)   ? {24'h0, cu_reg} :
	                       (s_axi_araddr == atx_pkg::REG_STAT) ? stat_word :
	                       ua_rd_hit ? ua_rword : 32'h0;

	assign s_axi_awready = ~aw_full_reg;
	assign s_axi_wready  = ~w_full_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// address and data are held until both are present
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid & ~aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid & ~w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// write response and read answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= atx_pkg::RESP_OKAY;
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= atx_pkg::RESP_OKAY;
		end else begin
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_known ? atx_pkg::RESP_OKAY : atx_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
			if (ar_take) begin
				rvalid_reg <= 1'b1;
				rdata_reg  <= rd_mux;
				rresp_reg  <= rd_known ? atx_pkg::RESP_OKAY : atx_pkg::RESP_SLVERR;
			end else if (s_axi_rready) begin
				rvalid_reg <= 1'b0;
			end
		end
	end

	// control registers; audio source resets to port A, pin to input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= atx_pkg::CTRL_RST;
			out_reg  <= atx_pkg::OUT_RST;
			cu_reg   <= atx_pkg::CU_RST;
		end else if (wr_lo) begin
			if (aw_addr_reg == atx_pkg::REG_CTRL) ctrl_reg <= w_data_reg[7:0];
			if (aw_addr_reg == atx_pkg::REG_OUT)  out_reg  <= w_data_reg[7:0];
			if (aw_addr_reg == atx_pkg::REG_CU)   cu_reg   <= w_data_reg[7:0];
		end
	end

	// user access buffer: word n holds byte n of cs left, cs right, u left, u right
	genvar k;
	generate
		for (k = 0; k < 4; k++) begin : g_ua
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ua_reg[k] <= '0;
				end else if (do_write & ua_wr_hit & w_strb_reg[k]) begin
					ua_reg[k][{ua_widx, 3'h0} +: 8] <= w_data_reg[k*8 +: 8];
				end
			end
		end
	endgenerate

	// ************************************************************
	// receiver status/user capture
	// ************************************************************
	// a finished block is handed over at the next receiver block start
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ra_cap_reg  <= '0;
			ra_done_reg <= '0;
			ra_idx_reg  <= 8'h00;
		end else if (rx_cu_strobe) begin
			for (int i = 0; i < 4; i++) begin
				ra_cap_reg[i][rx_block_start ? 8'h00 : ra_idx_reg] <= rx_cu_bits[i];
			end
			if (rx_block_start) begin
				ra_done_reg <= ra_cap_reg;
				ra_idx_reg  <= 8'h01;
			end else if (ra_idx_reg != atx_pkg::FRAME_LAST) begin
				ra_idx_reg  <= ra_idx_reg + 8'h01;
			end
		end
	end

	// ************************************************************
	// master clock division and frame timing
	// ************************************************************
	logic        mclk_d_reg;
	logic [1:0]  div_reg;
	logic [31:0] sf_reg;
	logic [7:0]  pre_reg;
	logic        pol_reg;
	logic        line_lvl_reg;
	logic [23:0] aud_r_reg;
	logic        v_reg;

	wire [1:0] div_sel  = ctrl_reg[atx_pkg::CTRL_DIV_LSB +: 2];
	wire       mclk_lvl = ctrl_reg[atx_pkg::CTRL_MSRC] ? recovered_clock_out : ext_mclk;
	wire       mclk_tick = mclk_lvl & ~mclk_d_reg;
	// half-cell every 1..4 master ticks: 128 half-cells per frame
	wire       hc_tick  = mclk_tick & (div_reg == div_sel);
	wire       sf_start = hc_tick & (hc_reg[5:0] == atx_pkg::SF_LAST);
	wire       frame_end = hc_tick & (hc_reg == atx_pkg::HC_LAST);
	wire       bs_dir_out = ctrl_reg[atx_pkg::CTRL_BSDIR];
	// external block start sampled at the frame boundary
	wire       bs_force = ~bs_dir_out & block_start_pin_i;
	wire [7:0] frame_next = (bs_force | (frame_reg == atx_pkg::FRAME_LAST)) ?
	                        8'h00 : frame_reg + 8'h01;
	wire       z_frame  = (frame_next == 8'h00);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mclk_d_reg <= 1'b0;
			div_reg    <= 2'h0;
		end else begin
			mclk_d_reg <= mclk_lvl;
			if (mclk_tick) div_reg <= hc_tick ? 2'h0 : div_reg + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hc_reg    <= atx_pkg::HC_LAST;
			frame_reg <= atx_pkg::FRAME_LAST;
		end else if (hc_tick) begin
			hc_reg <= hc_reg + 7'h01;
			if (frame_end) frame_reg <= frame_next;
		end
	end

	// ************************************************************
	// subframe assembly
	// ************************************************************
	wire [1:0]  src_sel = ctrl_reg[atx_pkg::CTRL_SRC_LSB +: 2];
	wire [23:0] aud_l   = (src_sel == atx_pkg::ATX_SRC_PORT_B) ? port_b_left :
	                      (src_sel == atx_pkg::ATX_SRC_RX) ? rx_left : port_a_left;
	wire [23:0] aud_r   = (src_sel == atx_pkg::ATX_SRC_PORT_B) ? port_b_right :
	                      (src_sel == atx_pkg::ATX_SRC_RX) ? rx_right : port_a_right;
	wire        v_src   = cu_reg[atx_pkg::CU_VSEL] ? rx_validity :
	                      ctrl_reg[atx_pkg::CTRL_VALID];
	wire        cu_rx   = cu_reg[atx_pkg::CU_SRC_LSB +: 2] == atx_pkg::ATX_CU_RX;
	wire [3:0][191:0] ta_src = cu_rx ? ra_done_reg : ua_reg;
	wire        is_left = hc_reg[6]; // next subframe is channel 1
	wire        mute    = out_reg[atx_pkg::OUT_MUTE];
	// bit index k: 0 cs left, 1 cs right, 2 u left, 3 u right
	wire        c_bit   = is_left ? (z_frame ? ta_src[0][0] : ta_reg[0][frame_next]) :
	                      ta_reg[1][frame_reg];
	wire        u_bit   = is_left ? (z_frame ? ta_src[2][0] : ta_reg[2][frame_next]) :
	                      ta_reg[3][frame_reg];
	wire [23:0] aud_now = mute ? 24'h0 : (is_left ? aud_l : aud_r_reg);
	wire        v_now   = is_left ? v_src : v_reg;
	wire [30:0] sf_body = {c_bit, u_bit, v_now, aud_now, 4'h0};
	wire [31:0] sf_new  = {^sf_body[30:atx_pkg::AUD_LSB], sf_body};
	wire [7:0]  pre_new = !is_left ? atx_pkg::PRE_Y :
	                      (z_frame ? atx_pkg::PRE_Z : atx_pkg::PRE_X);

	// load the next subframe and, for channel 1, snapshot the frame inputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sf_reg    <= 32'h0;
			pre_reg   <= atx_pkg::PRE_X;
			pol_reg   <= 1'b0;
			aud_r_reg <= 24'h0;
			v_reg     <= 1'b0;
			ta_reg    <= '0;
		end else if (sf_start) begin
			sf_reg  <= sf_new;
			pre_reg <= pre_new;
			pol_reg <= line_lvl_reg;
			if (is_left) begin
				aud_r_reg <= aud_r;
				v_reg     <= v_src;
				if (z_frame) ta_reg <= ta_src;
			end
		end
	end

	// ************************************************************
	// biphase mark line coding
	// ************************************************************
	wire [6:0] hc_nxt  = hc_reg + 7'h01;
	wire [4:0] slot    = hc_nxt[5:1];
	wire [7:0] pre_cur = sf_start ? pre_new : pre_reg;
	wire       pol_cur = sf_start ? line_lvl_reg : pol_reg;
	wire       pre_lvl = pre_cur[~{slot[1:0], hc_nxt[0]}] ^ pol_cur;
	wire       dat_lvl = (~hc_nxt[0] | sf_reg[slot]) ? ~line_lvl_reg : line_lvl_reg;
	wire       enc_lvl = (slot < atx_pkg::PRE_SLOTS) ? pre_lvl : dat_lvl;
	wire       byp_lvl = line_rx_in[out_reg[atx_pkg::OUT_BYP_LSB +: 2]];
	wire       ld_lvl  = out_reg[atx_pkg::OUT_LD_BYP] ? byp_lvl : line_lvl_reg;
	wire       cb_lvl  = out_reg[atx_pkg::OUT_CB_BYP] ? byp_lvl : line_lvl_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_lvl_reg <= 1'b0;
		end else if (hc_tick) begin
			line_lvl_reg <= enc_lvl;
		end
	end

	// output drivers with disables forcing low
	logic line_out_reg;
	logic cmos_out_reg;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			line_out_reg <= 1'b0;
			cmos_out_reg <= 1'b0;
		end else begin
			line_out_reg <= ld_lvl & ~out_reg[atx_pkg::OUT_LD_OFF];
			cmos_out_reg <= cb_lvl & ~out_reg[atx_pkg::OUT_CB_OFF];
		end
	end

	// frame sync and block start pin
	assign line_out           = line_out_reg;
	assign cmos_out           = cmos_out_reg;
	assign sync_out           = ~hc_reg[6];
	assign block_start_pin_oe = bs_dir_out;
	assign block_start_pin_o  = bs_dir_out & (frame_reg == 8'h00);

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_sync_rise_frame: assert property ($rose(sync_out) |-> hc_reg == 7'h00)
		else $error("frame sync rose away from frame start");
	chk_z_block_start: assert property (sf_start && is_left && z_frame |=>
		pre_reg == atx_pkg::PRE_Z && frame_reg == 8'h00)
		else $error("block start frame without Z preamble");
	chk_y_right_ch: assert property (sf_start && !is_left |=> pre_reg == atx_pkg::PRE_Y)
		else $error("channel 2 subframe without Y preamble");
	chk_parity_even: assert property (sf_start |=> ^sf_reg[31:4] == 1'b0)
		else $error("subframe parity is odd");
	chk_mute_zero: assert property (sf_start && mute |=> sf_reg[27:4] == 24'h0)
		else $error("muted subframe carries audio");
	chk_line_off_low: assert property (out_reg[atx_pkg::OUT_LD_OFF] |=> !line_out)
		else $error("line driver not low while disabled");
	chk_cmos_off_low: assert property (out_reg[atx_pkg::OUT_CB_OFF] |=> !cmos_out)
		else $error("cmos buffer not low while disabled");
	chk_bmc_cell_edge: assert property (hc_tick && slot >= atx_pkg::PRE_SLOTS && !hc_nxt[0]
		|=> line_lvl_reg != $past(line_lvl_reg))
		else $error("no transition at bit cell start");
	chk_bs_force_z: assert property (frame_end && bs_force |=> frame_reg == 8'h00)
		else $error("block start input did not restart block");
	chk_bs_out_frame: assert property (sf_start && is_left |=>
		block_start_pin_o == (bs_dir_out && pre_reg == atx_pkg::PRE_Z))
		else $error("block start output not aligned to Z frame");
endmodule

/* File: tb/atx_rx_model.sv */
// receiving end model: decodes the encoded line into preambles and subframe words
`timescale 1ns/1ps
module atx_rx_model (
	input	wire logic			aclk,
	input	wire logic			line_in,
	input	wire logic			sync_in,
	output	logic [7:0]			pre1,
	output	logic [7:0]			pre2,
	output	logic [31:0]		word1,
	output	logic [31:0]		word2,
	output	int					frames,
	output	int					bmc_errs
);
	logic	[127:0]	hc;
	logic			sync_d = 1'b0;
	logic			lvl = 1'b0;
	int				cnt = 1000;
	// ************************************************************
	// decode
	// ************************************************************
	// split one frame of half-cells into two subframes; level before a preamble sets polarity
	task automatic decode();
		logic [7:0]		p;
		logic [31:0]	w;
		for (int s = 0; s < 2; s++) begin
			for (int i = 0; i < 8; i++) p[7 - i] = hc[64 * s + i] ^ lvl;
			w = 32'h0;
			for (int b = 4; b < 32; b++) begin
				w[b] = hc[64 * s + 2 * b] ^ hc[64 * s + 2 * b + 1];
				// every data cell must open with a transition
				if (hc[64 * s + 2 * b] === hc[64 * s + 2 * b - 1]) bmc_errs++;
			end
			lvl = hc[64 * s + 63];
			if (s == 0) begin
				pre1 = p;
				word1 = w;
			end else begin
				pre2 = p;
				word2 = w;
			end
		end
		frames++;
	endtask
	// ************************************************************
	// capture
	// ************************************************************
	// falling-edge sampling keeps clear of the line's update edge; sync rise restarts a frame
	initial begin
		frames = 0;
		bmc_errs = 0;
	end
	always @(negedge aclk) begin
		sync_d <= sync_in;
		cnt = (sync_in && !sync_d) ? 0 : cnt + 1;
		if (cnt[0] && cnt < 256) hc[cnt / 2] = line_in;
		if (cnt == 255) decode();
	end
endmodule

/* File: tb/atx_tx_encoder_unit_tb.sv */
// self-checking bench for the transmit encoder
`timescale 1ns/1ps
module atx_tx_encoder_unit_tb;
	logic			aclk, aresetn, ext_mclk, recovered_clock_out, rx_validity, rx_cu_strobe;
	logic [11:0]	s_axi_awaddr, s_axi_araddr;
	logic [31:0]	s_axi_wdata, s_axi_rdata, word1, word2;
	logic [3:0]		s_axi_wstrb, line_rx_in, rx_cu_bits;
	logic [1:0]		s_axi_bresp, s_axi_rresp, rec_div;
	logic			s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic			s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [23:0]	port_a_left, port_a_right, port_b_left, port_b_right, rx_left, rx_right;
	logic			rx_block_start, line_out, cmos_out, sync_out, block_start_pin_i;
	logic			block_start_pin_o, block_start_pin_oe;
	logic [7:0]		pre1, pre2;
	int				frames, bmc_errs, failures, n_tests;

	atx_tx_encoder_unit i_atx_tx_encoder_unit (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .port_a_left, .port_a_right,
		.port_b_left, .port_b_right, .rx_left, .rx_right, .rx_validity, .rx_cu_strobe,
		.rx_block_start, .rx_cu_bits, .ext_mclk, .recovered_clock_out, .line_rx_in, .line_out,
		.cmos_out, .sync_out, .block_start_pin_i, .block_start_pin_o, .block_start_pin_oe);
	atx_rx_model i_atx_rx_model (.aclk, .line_in(line_out), .sync_in(sync_out), .pre1, .pre2,
		.word1, .word2, .frames, .bmc_errs);
	// ************************************************************
	// clocks and helpers
	// ************************************************************
	// bench clock; master clocks tick every 2 (external) and 4 (recovered) cycles
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		ext_mclk <= ~ext_mclk;
		rec_div <= rec_div + 2'h1;
		recovered_clock_out <= rec_div[1];
	end
	function automatic logic [31:0] sf(input logic [23:0] a, input logic v, u, c);
		logic [31:0] w;
		w = {1'b0, c, u, v, a, 4'h0};
		w[31] = ^w[30:4];
		return w;
	endfunction
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task automatic words(input logic [31:0] e1, input logic [31:0] e2);
		check("channel 1 word", e1, word1);
		check("channel 2 word", e2, word2);
	endtask
	task automatic wait_frames(input int n);
		int f0;
		f0 = frames;
		wait (frames >= f0 + n);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		check("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		check("rdata", ed, s_axi_rdata);
		check("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_regs();
		check("pin enable", 32'h0, {31'h0, block_start_pin_oe});
		rd(atx_pkg::REG_CTRL, 32'h0);
		rd(atx_pkg::REG_OUT, 32'h0);
		rd(atx_pkg::REG_CU, 32'h0);
		wr(12'h200, 32'h1, atx_pkg::RESP_SLVERR);
		rd(12'h200, 32'h0, atx_pkg::RESP_SLVERR);
		s_axi_wstrb <= 4'he;
		wr(atx_pkg::REG_CTRL, 32'h1);
		s_axi_wstrb <= 4'hf;
		rd(atx_pkg::REG_CTRL, 32'h0);
	endtask
	task automatic t_format();
		wait_frames(3);
		words(sf(port_a_left, 0, 0, 0), sf(port_a_right, 0, 0, 0));
		check("preamble 1", {24'h0, atx_pkg::PRE_X}, {24'h0, pre1});
		check("preamble 2", {24'h0, atx_pkg::PRE_Y}, {24'h0, pre2});
	endtask
	task automatic t_block_in();
		logic [3:0] b;
		wr(atx_pkg::UA_BASE, 32'h08040201);
		wait_frames(1);
		@(posedge aclk);
		block_start_pin_i <= 1'b1;
		wait_frames(1);
		repeat (20) @(posedge aclk);
		block_start_pin_i <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			wait_frames(1);
			b = 4'h1 << i;
			check("preamble 1", {24'h0, (i == 0) ? atx_pkg::PRE_Z : atx_pkg::PRE_X}, {24'h0, pre1});
			words(sf(port_a_left, 0, b[2], b[0]), sf(port_a_right, 0, b[3], b[1]));
		end
		@(posedge aclk);
		{rx_cu_strobe, rx_block_start, rx_cu_bits} <= 6'h3f;
		@(posedge aclk);
		rx_cu_bits <= 4'h0;
		@(posedge aclk);
		{rx_cu_strobe, rx_block_start, block_start_pin_i} <= 3'h1;
		wr(atx_pkg::REG_CU, 32'h1);
		wait_frames(2);
		words(sf(port_a_left, 0, 1, 1), sf(port_a_right, 0, 1, 1));
		@(posedge aclk);
		block_start_pin_i <= 1'b0;
		check("line code faults", 32'h0, 32'(bmc_errs));
	endtask
	task automatic t_sources();
		logic [23:0] l [3];
		logic [23:0] r [3];
		l = '{port_a_left, port_b_left, rx_left};
		r = '{port_a_right, port_b_right, rx_right};
		for (int s = 0; s < 3; s++) begin
			wr(atx_pkg::REG_CTRL, 32'(s));
			wait_frames(3);
			words(sf(l[s], 0, 0, 0), sf(r[s], 0, 0, 0));
		end
		wr(atx_pkg::REG_OUT, 32'h4);
		wait_frames(3);
		words(sf(24'h0, 0, 0, 0), sf(24'h0, 0, 0, 0));
		wr(atx_pkg::REG_OUT, 32'h0);
		wr(atx_pkg::REG_CTRL, 32'h21);
		wait_frames(3);
		words(sf(port_b_left, 1, 0, 0), sf(port_b_right, 1, 0, 0));
		wr(atx_pkg::REG_CU, 32'h4);
		wait_frames(3);
		words(sf(port_b_left, 0, 0, 0), sf(port_b_right, 0, 0, 0));
		@(posedge aclk);
		rx_validity <= 1'b1;
		wait_frames(3);
		words(sf(port_b_left, 1, 0, 0), sf(port_b_right, 1, 0, 0));
		wr(atx_pkg::REG_CU, 32'h0);
		wr(atx_pkg::REG_CTRL, 32'h0);
	endtask
	task automatic t_outputs();
		for (int i = 0; i < 4; i++) begin
			wr(atx_pkg::REG_OUT, 32'h18 | 32'(i << 5));
			line_rx_in <= 4'h1 << i;
			repeat (3) @(posedge aclk);
			check("bypass", 32'h3, {30'h0, line_out, cmos_out});
			line_rx_in <= ~(4'h1 << i);
			repeat (3) @(posedge aclk);
			check("bypass", 32'h0, {30'h0, line_out, cmos_out});
		end
		line_rx_in <= 4'hf;
		wr(atx_pkg::REG_OUT, 32'h1b);
		repeat (3) @(posedge aclk);
		check("disabled", 32'h0, {30'h0, line_out, cmos_out});
		wr(atx_pkg::REG_OUT, 32'h1a);
		repeat (3) @(posedge aclk);
		check("disabled", 32'h2, {30'h0, line_out, cmos_out});
		wr(atx_pkg::REG_OUT, 32'h0);
	endtask
	task automatic t_divider();
		time t0;
		for (int d = 0; d < 5; d++) begin
			wr(atx_pkg::REG_CTRL, (d == 4) ? 32'h10 : 32'(d << 2));
			@(posedge sync_out);
			@(posedge sync_out);
			t0 = $time;
			@(posedge sync_out);
			check("frame period", (d == 4) ? 32'd512 : 32'(256 * (d + 1)), 32'(($time - t0) / 100));
		end
		wr(atx_pkg::REG_CTRL, 32'h0);
		wait_frames(2);
	endtask
	task automatic t_block_out();
		int n;
		wr(atx_pkg::REG_CTRL, 32'h40);
		check("pin enable", 32'h1, {31'h0, block_start_pin_oe});
		wait (block_start_pin_o === 1'b1);
		@(negedge aclk);
		check("sync at block start", 32'h1, {31'h0, sync_out});
		n = 0;
		while (block_start_pin_o === 1'b1) begin
			@(negedge aclk);
			n++;
		end
		check("block start length", 32'd256, 32'(n));
		check("block start preamble", {24'h0, atx_pkg::PRE_Z}, {24'h0, pre1});
	endtask
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	// a full block fits inside the limit
	initial begin
		#9000000;
		failures++;
		complete_run();
	end
	initial begin
		{aresetn, ext_mclk, recovered_clock_out, rec_div, rx_validity, rx_cu_strobe} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, rx_block_start, rx_cu_bits} = '0;
		{line_rx_in, block_start_pin_i} = '0;
		s_axi_wstrb = 4'hf;
		{port_a_left, port_a_right} = {24'h123456, 24'h876543};
		{port_b_left, port_b_right} = {24'h0f1e2d, 24'hf00001};
		{rx_left, rx_right} = {24'h5a5a5a, 24'h00a5ff};
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_format();
		t_block_in();
		t_sources();
		t_outputs();
		t_divider();
		t_block_out();
		complete_run();
	end
endmodule
